// ---- rtl/frp_pkg.sv ----
package frp_pkg;
	localparam int unsigned CTL_W          = 16;
	localparam int unsigned BIT_START      = 15;
	localparam int unsigned BIT_ENABLE     = 14;
	localparam int unsigned BIT_SEQ_ERR    = 13;
	localparam int unsigned BIT_ERASE      = 6;
	localparam int unsigned OP_LSB         = 0;
	localparam int unsigned OP_W           = 4;
	localparam logic [15:0] CTL_RESET      = 16'h0000;
	localparam logic [15:0] CTL_WMASK      = 16'h404F;
	localparam logic [3:0]  OP_PAGE_ERASE  = 4'h2;
	localparam logic [3:0]  OP_ROW_PROG    = 4'h1;
	localparam logic [7:0]  KEY_FIRST      = 8'h55;
	localparam logic [7:0]  KEY_SECOND     = 8'hAA;
	localparam int unsigned ROW_WORDS      = 64;
	localparam int unsigned PAGE_WORDS     = 512;
	localparam int unsigned ADDR_W         = 24;
	localparam int unsigned WORD_W         = 24;
	localparam int unsigned ROW_AW         = $clog2(ROW_WORDS);
	// word address = byte address / 2 (two address units per instruction)
	localparam int unsigned PAGE_ALIGN     = $clog2(PAGE_WORDS) + 1;
	localparam int unsigned ROW_ALIGN      = ROW_AW + 1;
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned OP_TIME_US     = 4_000;
	localparam int unsigned OP_CYCLES      = OP_TIME_US * (CLK_HZ / 1_000_000);
	typedef enum logic [1:0] {FRP_IDLE, FRP_ERASE, FRP_PROG} frp_state_e;
endpackage : frp_pkg

// ---- rtl/frp_row_buffer.sv ----
`timescale 1ns/1ps
// holding latches for one row; low word and high byte written separately
module frp_row_buffer
	import frp_pkg::*;
#(
	parameter int unsigned DEPTH = ROW_WORDS,
	parameter int unsigned AW    = ROW_AW
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              wr_low,
	input  wire logic              wr_high,
	input  wire logic [AW-1:0]     wr_index,
	input  wire logic [15:0]       wr_low_data,
	input  wire logic [7:0]        wr_high_data,
	input  wire logic [AW-1:0]     rd_index,
	output logic      [WORD_W-1:0] rd_data
);
	logic [WORD_W-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_low) begin
			mem[wr_index][15:0] <= wr_low_data;
		end
		if (wr_high) begin
			mem[wr_index][23:16] <= wr_high_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_index];
		end
	end
endmodule : frp_row_buffer

// ---- rtl/frp_sequencer.sv ----
`timescale 1ns/1ps
// Contract
// - select field 0010 with erase and enable set starts page erase
// - an operation runs only after keys 55h then AAh
// - start bit begins erase, cpu stalls, start bit clears when done
// - select 0001, erase clear, enable set starts row programming
// - row programming stalls the cpu, start bit self-clears when written
// - low store fills bits 15:0, high store fills 23:16, latch picked by table address bits 6:1
// - sequence error set on an improper start or termination
// - each self-timed operation lasts nominally 4 ms
// - key register is write-only, eight bits, reads zero
// - cleared enable bit inhibits every program and erase
module frp_sequencer
	import frp_pkg::*;
#(
	parameter int unsigned OP_CYCLES_P = OP_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              ctl_wr,
	input  wire logic [CTL_W-1:0]  ctl_wdata,
	output logic      [CTL_W-1:0]  ctl_rdata,
	input  wire logic              key_wr,
	input  wire logic [CTL_W-1:0]  key_wdata,
	output logic      [CTL_W-1:0]  key_rdata,
	input  wire logic              other_wr,
	input  wire logic              abort_op,
	input  wire logic              store_low,
	input  wire logic              store_high,
	input  wire logic [ADDR_W-1:0] table_addr,
	input  wire logic [15:0]       store_data,
	output logic                   cpu_stall,
	output logic                   flash_erase,
	output logic                   flash_prog,
	output logic      [ADDR_W-1:0] flash_addr,
	output logic      [ROW_AW-1:0] flash_index,
	output logic      [WORD_W-1:0] flash_wdata,
	output logic                   op_done
);
	localparam int unsigned AW_O = ROW_AW;
	localparam int unsigned CNT_W = $clog2(OP_CYCLES_P + 1);

	typedef enum logic [1:0] {KEY_NONE, KEY_GOT55, KEY_ARMED} frp_key_e;

	frp_state_e       state;
	frp_state_e       next_state;
	frp_key_e         key_state;
	frp_key_e         next_key_state;
	logic             start;
	logic             enable;
	logic             seq_err;
	logic             erase_sel;
	logic [OP_W-1:0]  op_sel;
	logic [CNT_W-1:0] timer;
	logic [ADDR_W-1:0] op_addr;
	logic [ADDR_W-1:0] latch_addr;
	logic [AW_O-1:0]  rd_index;

	function automatic logic [ADDR_W-1:0] align_down(
		input logic [ADDR_W-1:0] a,
		input int unsigned       bits
	);
		logic [ADDR_W-1:0] m;
		// clears the low bits so any address inside a page or row picks its base
		m = '1;
		align_down = a & (m << bits);
	endfunction : align_down

	wire logic set_start   = ctl_wr && ctl_wdata[BIT_START] && !start;
	wire logic is_erase    = erase_sel && (op_sel == OP_PAGE_ERASE);
	wire logic is_prog     = !erase_sel && (op_sel == OP_ROW_PROG);
	// keys must be the last two writes before start; any other write disarms
	wire logic armed       = (key_state == KEY_ARMED);
	// the op check sees the fields stored before this write, so config first
	wire logic go          = set_start && armed && enable
	                         && (is_erase || is_prog);
	wire logic bad_start   = set_start && !go;
	// compare against one less: the op then spans exactly OP_CYCLES_P cycles
	wire logic timer_done  = (timer == CNT_W'(OP_CYCLES_P - 1));
	wire logic busy        = (state != FRP_IDLE);
	wire logic terminate   = busy && abort_op;
	wire logic op_end      = busy && (timer_done || terminate);
	// control is frozen while busy since the cpu is stalled
	wire logic ctl_take    = ctl_wr && !busy;
	// a fresh 55h restarts the pair at any time, even when already armed
	wire logic key_first   = key_wr && (key_wdata[7:0] == KEY_FIRST);
	wire logic key_second  = key_wr && (key_wdata[7:0] == KEY_SECOND);
	// table stores are writes as well, so they break the pair too
	wire logic disarm      = ctl_wr || other_wr || store_low || store_high;

	// unimplemented bits read back as zero
	assign ctl_rdata = {start, enable, seq_err, 6'h00, erase_sel,
	                    2'b00, op_sel};
	assign key_rdata = '0;
	// stall follows the state register, so it drops with the start bit
	assign cpu_stall = busy;
	assign flash_erase = (state == FRP_ERASE);
	assign flash_prog  = (state == FRP_PROG);
	assign flash_addr  = op_addr;

	always_comb begin
		next_state = state;
		case (state)
			FRP_IDLE: begin
				if (go) begin
					next_state = is_erase ? FRP_ERASE : FRP_PROG;
				end
			end
			FRP_ERASE, FRP_PROG: begin
				if (timer_done || terminate) begin
					next_state = FRP_IDLE;
				end
			end
			default: next_state = FRP_IDLE;
		endcase
	end

	always_comb begin
		next_key_state = key_state;
		if (key_first) begin
			next_key_state = KEY_GOT55;
		end else if (key_second && key_state == KEY_GOT55) begin
			next_key_state = KEY_ARMED;
		end else if (key_wr || disarm) begin
			next_key_state = KEY_NONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			key_state <= KEY_NONE;
		end else begin
			key_state <= next_key_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state     <= FRP_IDLE;
			start     <= CTL_RESET[BIT_START];
			enable    <= CTL_RESET[BIT_ENABLE];
			seq_err   <= CTL_RESET[BIT_SEQ_ERR];
			erase_sel <= CTL_RESET[BIT_ERASE];
			op_sel    <= CTL_RESET[OP_LSB +: OP_W];
			timer     <= '0;
			op_addr   <= '0;
			op_done   <= 1'b0;
		end else begin
			state   <= next_state;
			op_done <= op_end;
			timer   <= busy ? timer + CNT_W'(1) : '0;
			if (ctl_take) begin
				enable    <= ctl_wdata[BIT_ENABLE];
				erase_sel <= ctl_wdata[BIT_ERASE];
				op_sel    <= ctl_wdata[OP_LSB +: OP_W];
			end
			if (go) begin
				start   <= 1'b1;
				op_addr <= is_erase ? align_down(latch_addr, PAGE_ALIGN)
				                    : align_down(latch_addr, ROW_ALIGN);
			end else if (op_end) begin
				start <= 1'b0;
			end
			// set wins over a software clear written in the same cycle
			if (bad_start || terminate) begin
				seq_err <= 1'b1;
			end else if (go) begin
				seq_err <= 1'b0;
			end else if (ctl_take) begin
				seq_err <= ctl_wdata[BIT_SEQ_ERR];
			end
		end
	end

	// remembers the last table address; an erase takes its page from it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			latch_addr <= '0;
		end else if (store_low || store_high) begin
			latch_addr <= table_addr;
		end
	end

	// the flash array is fed one latch per cycle during programming
	// the index lags the read address a cycle to pair with the latch output
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_index    <= '0;
			flash_index <= '0;
		end else begin
			rd_index    <= flash_prog ? rd_index + AW_O'(1) : '0;
			flash_index <= rd_index;
		end
	end

	frp_row_buffer #(
		.DEPTH (ROW_WORDS),
		.AW    (AW_O)
	) u_buf (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.wr_low       (store_low && !busy),
		.wr_high      (store_high && !busy),
		.wr_index     (table_addr[ROW_AW:1]),
		.wr_low_data  (store_data),
		.wr_high_data (store_data[7:0]),
		.rd_index     (rd_index),
		.rd_data      (flash_wdata)
	);
endmodule : frp_sequencer

// ---- sim/frp_chk_sva.sv ----
`timescale 1ns/1ps
module frp_chk
	import frp_pkg::*;
#(parameter int unsigned OP_CYCLES_P = 20) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        ctl_wr,
	input wire logic [15:0] ctl_wdata,
	input wire logic [15:0] ctl_rdata,
	input wire logic        key_wr,
	input wire logic [15:0] key_wdata,
	input wire logic [15:0] key_rdata,
	input wire logic        abort_op,
	input wire logic        cpu_stall,
	input wire logic        flash_erase,
	input wire logic [23:0] flash_addr
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	int unsigned run;
	always_ff @(posedge ref_clk) run <= (cpu_stall && !reset) ? run + 1 : 0;
	sequence keys_s;
		key_wr && key_wdata[7:0] == 8'h55 ##1 key_wr && key_wdata[7:0] == 8'hAA
		##1 ctl_wr && ctl_wdata[15] && ctl_rdata[14] && !cpu_stall;
	endsequence
	key_zero_a: assert property (key_rdata == '0)
		else $error("key readback");
	stall_start_a: assert property (cpu_stall == ctl_rdata[15])
		else $error("stall vs start");
	erase_go_a: assert property (
		keys_s ##0 ctl_rdata[6:0] == 7'h42 |=> flash_erase && cpu_stall
	) else $error("erase not run");
	prog_go_a: assert property (
		keys_s ##0 ctl_rdata[6:0] == 7'h01 |=> cpu_stall && !flash_erase
	) else $error("program not run");
	no_enable_a: assert property (
		ctl_wr && ctl_wdata[15] && !ctl_rdata[14] && !cpu_stall
		|=> !cpu_stall && ctl_rdata[13]) else $error("ran disabled");
	no_key_a: assert property (
		ctl_wr && ctl_wdata[15] && $past(ctl_wr) && !cpu_stall
		|=> !cpu_stall && ctl_rdata[13]) else $error("ran unkeyed");
	op_len_a: assert property (
		$fell(cpu_stall) && !$past(abort_op) |-> run == OP_CYCLES_P
	) else $error("bad duration");
	abort_err_a: assert property (
		cpu_stall && abort_op |=> ctl_rdata[13]) else $error("abort flag");
	page_align_a: assert property (
		flash_erase |-> flash_addr[9:0] == 10'h000) else $error("page");
endmodule : frp_chk
bind frp_sequencer frp_chk #(.OP_CYCLES_P(OP_CYCLES_P)) chk_i (
	.ref_clk     (ref_clk),
	.reset       (reset),
	.ctl_wr      (ctl_wr),
	.ctl_wdata   (ctl_wdata),
	.ctl_rdata   (ctl_rdata),
	.key_wr      (key_wr),
	.key_wdata   (key_wdata),
	.key_rdata   (key_rdata),
	.abort_op    (abort_op),
	.cpu_stall   (cpu_stall),
	.flash_erase (flash_erase),
	.flash_addr  (flash_addr)
);

// ---- sim/frp_cpu.sv ----
`timescale 1ns/1ps
// strobe order {abort,high,low,other,key,ctl}
module frp_cpu (
	input  wire logic        ref_clk,
	output logic      [5:0]  stb,
	output logic      [15:0] wd,
	output logic      [23:0] ta
);
	initial {stb, wd, ta} = '0;
	task automatic op(input logic [5:0] s, input logic [15:0] d,
		input logic [23:0] a);
		@(posedge ref_clk);
		#1;
		stb = s;
		// idle data toggles so nothing stale looks valid
		wd = (s == 6'h00) ? ~wd : d;
		ta = a;
	endtask : op
	// keys back to back: any write between them other than another 55h would disarm
	task automatic go(input logic [15:0] cfg, input logic [23:0] a);
		op(6'h02, 16'h0055, a);
		op(6'h02, 16'h00AA, a);
		op(6'h01, cfg | 16'h8000, a);
		op(6'h00, 16'h0000, a);
		op(6'h00, 16'h0000, a);
	endtask : go
endmodule : frp_cpu

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic        ref_clk, reset, stall, done;
	logic [5:0]  stb;
	logic [15:0] wd, crd, krd;
	logic [23:0] ta, fa, fw, wa;
	logic [23:0] row_exp[64];
	logic [5:0]  fi;
	logic        fp;
	logic [31:0] rs;
	logic [15:0] expq[$];
	logic [15:0] bad_ops[3] = '{16'h4041, 16'h4002, 16'h4003};
	int          bad_count, checks_done, i;
	frp_cpu cpu (.ref_clk(ref_clk), .stb(stb), .wd(wd), .ta(ta));
	frp_sequencer #(.OP_CYCLES_P(70)) uut (.ref_clk(ref_clk),
		.reset(reset), .ctl_wr(stb[0]), .ctl_wdata(wd), .ctl_rdata(crd),
		.key_wr(stb[1]), .key_wdata(wd), .key_rdata(krd),
		.other_wr(stb[2]), .abort_op(stb[5]), .store_low(stb[3]),
		.store_high(stb[4]), .table_addr(ta), .store_data(wd),
		.cpu_stall(stall), .flash_erase(), .flash_prog(fp), .flash_addr(fa),
		.flash_index(fi), .flash_wdata(fw), .op_done(done));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [23:0] e,
		input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic finish_op;
		for (i = 0; i < 100 && stall !== 1'b0; i++)
			cpu.op(6'h00, 16'h0000, ta);
		if (i == 100) begin
			bad_count++;
			summarize();
		end
		repeat (3) cpu.op(6'h00, 16'h0000, ta);
	endtask : finish_op
	task automatic trial(input logic [15:0] c, input logic ok,
		input logic [23:0] a);
		cpu.op(6'h01, c, a);
		if (ok)
			expq.push_back(c);
		cpu.go(c, a);
		if (ok)
			finish_op();
		cpu.op(6'h00, 16'h0000, a);
		chk("seq_err", !ok, crd[13]);
		chk("stall", 0, stall);
	endtask : trial
	// a done pulse with no pending note is ignored; nothing else checks it
	always @(negedge ref_clk)
		if (done === 1'b1 && expq.size() > 0)
			chk("ctl_done", expq.pop_front(), crd);
	// every latch streamed to the array must be the word loaded there
	always @(negedge ref_clk)
		if (fp === 1'b1)
			chk("row_word", row_exp[fi], fw);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		{reset, rs, bad_count, checks_done} = {1'b1, 32'h0000_6090, 64'h0};
		repeat (16) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		chk("ctl_reset", 0, crd);
		cpu.op(6'h02, 16'h00A5, ta);
		chk("key_read", 0, krd);
		trial(16'h0042, 0, ta);
		cpu.op(6'h01, 16'h4042, ta);
		cpu.op(6'h01, 16'hC042, ta);
		cpu.op(6'h00, 16'h0000, ta);
		chk("unkeyed", 1, crd[13]);
		cpu.op(6'h01, 16'h4042, ta);
		cpu.op(6'h02, 16'h0055, ta);
		cpu.op(6'h04, 16'h0000, ta);
		cpu.op(6'h02, 16'h00AA, ta);
		cpu.op(6'h01, 16'hC042, ta);
		cpu.op(6'h00, 16'h0000, ta);
		chk("split_keys", 1, crd[13]);
		chk("split_stall", 0, stall);
		foreach (bad_ops[k])
			trial(bad_ops[k], 0, ta);
		rs = lfsr(rs);
		cpu.op(6'h08, 16'h0000, rs[23:0]);
		trial(16'h4042, 1, rs[23:0]);
		chk("page", {rs[23:10], 10'h000}, fa);
		for (int r = 0; r < 2; r++) begin
			for (int j = 0; j < 64; j++) begin
				rs = lfsr(rs);
				row_exp[j] = rs[23:0];
				wa = 24'(128 * r + 2 * j);
				cpu.op(6'h08, rs[15:0], wa);
				cpu.op(6'h10, {8'h00, rs[23:16]}, wa);
			end
			trial(16'h4001, 1, ta);
			chk("row_addr", 24'(128 * r), fa);
		end
		cpu.op(6'h01, 16'h4042, ta);
		cpu.go(16'h4042, ta);
		cpu.op(6'h20, 16'h0000, ta);
		finish_op();
		chk("abort_err", 1, crd[13]);
		chk("pending", 0, 24'(expq.size()));
		summarize();
	end
endmodule : tb
